/* File: verilog/ataf_pkg.sv */
// Constants and types for the task-file command interpreter
`default_nettype none
package ataf_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_SCNT = 8'h04;
  localparam logic [7:0] OFF_CYLL = 8'h08;
  localparam logic [7:0] OFF_CYLH = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_CFG = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  // Status and control bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_SLEEP = 2;
  localparam int ST_DONE = 3;
  localparam int ER_ABRT = 2;
  localparam int CT_SRST = 0;
  // Opcodes
  localparam logic [7:0] CMD_SETF = 8'hef;
  localparam logic [7:0] CMD_SETM = 8'hc6;
  localparam logic [7:0] CMD_SLP1 = 8'he6;
  localparam logic [7:0] CMD_SLP2 = 8'h99;
  localparam logic [7:0] CMD_SMRT = 8'hb0;
  // Feature codes
  localparam logic [7:0] F_B8ON = 8'h01;
  localparam logic [7:0] F_B8OFF = 8'h81;
  localparam logic [7:0] F_WCON = 8'h02;
  localparam logic [7:0] F_WCOFF = 8'h82;
  localparam logic [7:0] F_XFER = 8'h03;
  localparam logic [7:0] F_PWON = 8'h09;
  localparam logic [7:0] F_PWOFF = 8'h89;
  localparam logic [7:0] F_RLOFF = 8'h55;
  localparam logic [7:0] F_RLON = 8'haa;
  localparam logic [7:0] F_KEEP = 8'h66;
  localparam logic [7:0] F_REST = 8'hcc;
  localparam logic [7:0] F_NOP1 = 8'h69;
  localparam logic [7:0] F_NOP2 = 8'h96;
  localparam logic [7:0] F_NOP3 = 8'h97;
  // Transfer types, bits 7:3 of the sector count value
  localparam logic [4:0] XT_PIOD = 5'h00;
  localparam logic [4:0] XT_PIOF = 5'h01;
  localparam logic [4:0] XT_MWDMA = 5'h04;
  localparam logic [4:0] XT_UDMA = 5'h08;
  localparam logic [2:0] XM_DEF = 3'h0;
  localparam logic [2:0] XM_NORDY = 3'h1;
  // Reliability signature and subcommands
  localparam logic [7:0] SIG_LO = 8'h4f;
  localparam logic [7:0] SIG_HI = 8'hc2;
  localparam logic [7:0] BAD_LO = 8'hf4;
  localparam logic [7:0] BAD_HI = 8'h2c;
  localparam logic [7:0] SUB_STAT = 8'hda;
  localparam logic [7:0] SUB_ASAV = 8'hd2;
  localparam logic [7:0] ASAV_OFF = 8'h00;
  localparam logic [7:0] ASAV_ON = 8'hf1;
  // Idle timer
  localparam int IDLE_MS = 15;
  localparam int CLK_KHZ = 40000;
  localparam int IDLE_CYC = IDLE_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_FLSH = 3'b100
  } ataf_state_e;
  typedef struct packed {
    logic byte_mode;
    logic wcache;
    logic iordy_dis;
    logic [2:0] pio_mode;
    logic mw_en;
    logic [2:0] mw_mode;
    logic udma_en;
    logic [2:0] udma_mode;
    logic ext_pwr;
    logic lookahead;
    logic autosave;
    logic multi_en;
    logic [7:0] multi_cnt;
  } ataf_cfg_s;
  localparam ataf_cfg_s CFG_RST = '0;
endpackage
`default_nettype wire

/* File: verilog/ataf_top.sv */
// Task-file command interpreter for feature, multiple, sleep, SMART
`timescale 1ns/1ps
`default_nettype none
module ataf_top #(
  parameter int IDLE_CYCLES = ataf_pkg::IDLE_CYC,
  parameter logic [7:0] MAX_MULTI = 8'h80,
  parameter logic [2:0] MAX_PIO = 3'h7,
  parameter logic [2:0] MAX_MW = 3'h7,
  parameter logic [2:0] MAX_UDMA = 3'h7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fatal_err,
  input wire logic flush_done,
  output ataf_pkg::ataf_cfg_s cfg,
  output logic data16_ok,
  output logic flush_req,
  output logic sleep,
  output logic busy,
  output logic cmd_done
);
  localparam int TW = $clog2(IDLE_CYCLES + 1);
  localparam logic [TW-1:0] T_END = TW'(IDLE_CYCLES - 1);

  ataf_pkg::ataf_state_e state_reg;
  ataf_pkg::ataf_cfg_s cfg_next;
  logic [7:0] feat_reg, scnt_reg, cyll_reg, cylh_reg, op_reg;
  logic [7:0] cyll_next, cylh_next;
  logic keep_reg, fatal_reg, err_reg, done_reg, abort_next, flush_next;
  logic [TW-1:0] idle_cnt;
  logic acc, wr_acc, rd_acc, cmd_go, srst_go, st_rd, exec, mapped;
  logic [31:0] rdata_next;

  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite & ~pslverr & pstrb[0];
  assign rd_acc = acc & ~pwrite;
  assign cmd_go = wr_acc & (paddr == ataf_pkg::OFF_CMD) & ~busy;
  assign srst_go = wr_acc & (paddr == ataf_pkg::OFF_CTRL) &
                   pwdata[ataf_pkg::CT_SRST];
  assign st_rd = rd_acc & (paddr == ataf_pkg::OFF_CMD);
  assign exec = (state_reg == ataf_pkg::S_EXEC);

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rdata_next = 32'h0000_0000;
    if (paddr == ataf_pkg::OFF_FEAT) begin
      rdata_next[ataf_pkg::ER_ABRT] = err_reg;
    end else if (paddr == ataf_pkg::OFF_SCNT) begin
      rdata_next[7:0] = scnt_reg;
    end else if (paddr == ataf_pkg::OFF_CYLL) begin
      rdata_next[7:0] = cyll_reg;
    end else if (paddr == ataf_pkg::OFF_CYLH) begin
      rdata_next[7:0] = cylh_reg;
    end else if (paddr == ataf_pkg::OFF_CMD) begin
      rdata_next[ataf_pkg::ST_BUSY] = busy;
      rdata_next[ataf_pkg::ST_ERR] = err_reg;
      rdata_next[ataf_pkg::ST_SLEEP] = sleep;
      rdata_next[ataf_pkg::ST_DONE] = done_reg;
    end else if (paddr == ataf_pkg::OFF_CFG) begin
      rdata_next[$bits(ataf_pkg::ataf_cfg_s)-1:0] = cfg;
    end else if (paddr == ataf_pkg::OFF_CTRL) begin
      rdata_next[0] = keep_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        prdata <= rdata_next;
      end
    end
  end

  // Task-file registers; host writes ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_reg <= 8'h00;
      scnt_reg <= 8'h00;
      cyll_reg <= 8'h00;
      cylh_reg <= 8'h00;
      op_reg <= 8'h00;
    end else if (exec) begin
      cyll_reg <= cyll_next;
      cylh_reg <= cylh_next;
    end else if (wr_acc & ~busy) begin
      if (paddr == ataf_pkg::OFF_FEAT) begin
        feat_reg <= pwdata[7:0];
      end else if (paddr == ataf_pkg::OFF_SCNT) begin
        scnt_reg <= pwdata[7:0];
      end else if (paddr == ataf_pkg::OFF_CYLL) begin
        cyll_reg <= pwdata[7:0];
      end else if (paddr == ataf_pkg::OFF_CYLH) begin
        cylh_reg <= pwdata[7:0];
      end else if (paddr == ataf_pkg::OFF_CMD) begin
        op_reg <= pwdata[7:0];
      end
    end
  end

  // Command decode
  always_comb begin
    cfg_next = cfg;
    abort_next = 1'b0;
    flush_next = 1'b0;
    cyll_next = cyll_reg;
    cylh_next = cylh_reg;
    case (op_reg)
      ataf_pkg::CMD_SETF: begin
        case (feat_reg)
          ataf_pkg::F_B8ON: cfg_next.byte_mode = 1'b1;
          ataf_pkg::F_B8OFF: cfg_next.byte_mode = 1'b0;
          ataf_pkg::F_WCON: cfg_next.wcache = 1'b1;
          ataf_pkg::F_WCOFF: begin
            cfg_next.wcache = 1'b0;
            flush_next = cfg.wcache;
          end
          ataf_pkg::F_XFER: begin
            case (scnt_reg[7:3])
              ataf_pkg::XT_PIOD: begin
                if (scnt_reg[2:0] == ataf_pkg::XM_DEF ||
                    scnt_reg[2:0] == ataf_pkg::XM_NORDY) begin
                  cfg_next.pio_mode = 3'h0;
                  cfg_next.iordy_dis = scnt_reg[0];
                end else begin
                  abort_next = 1'b1;
                end
              end
              ataf_pkg::XT_PIOF: begin
                if (scnt_reg[2:0] <= MAX_PIO) begin
                  cfg_next.pio_mode = scnt_reg[2:0];
                  cfg_next.iordy_dis = 1'b0;
                end else begin
                  abort_next = 1'b1;
                end
              end
              ataf_pkg::XT_MWDMA: begin
                if (scnt_reg[2:0] <= MAX_MW) begin
                  cfg_next.mw_en = 1'b1;
                  cfg_next.mw_mode = scnt_reg[2:0];
                  cfg_next.udma_en = 1'b0;
                end else begin
                  abort_next = 1'b1;
                end
              end
              ataf_pkg::XT_UDMA: begin
                if (scnt_reg[2:0] <= MAX_UDMA) begin
                  cfg_next.udma_en = 1'b1;
                  cfg_next.udma_mode = scnt_reg[2:0];
                  cfg_next.mw_en = 1'b0;
                end else begin
                  abort_next = 1'b1;
                end
              end
              default: abort_next = 1'b1;
            endcase
          end
          ataf_pkg::F_PWON: cfg_next.ext_pwr = 1'b1;
          ataf_pkg::F_PWOFF: cfg_next.ext_pwr = 1'b0;
          ataf_pkg::F_RLOFF: cfg_next.lookahead = 1'b0;
          ataf_pkg::F_RLON: cfg_next.lookahead = 1'b1;
          ataf_pkg::F_KEEP, ataf_pkg::F_REST: begin
          end
          ataf_pkg::F_NOP1, ataf_pkg::F_NOP2, ataf_pkg::F_NOP3: begin
          end
          default: abort_next = 1'b1;
        endcase
      end
      ataf_pkg::CMD_SETM: begin
        if (scnt_reg == 8'h00) begin
          cfg_next.multi_en = 1'b0;
        end else if (scnt_reg <= MAX_MULTI) begin
          cfg_next.multi_en = 1'b1;
          cfg_next.multi_cnt = scnt_reg;
        end else begin
          cfg_next.multi_en = 1'b0;
          abort_next = 1'b1;
        end
      end
      ataf_pkg::CMD_SLP1, ataf_pkg::CMD_SLP2: begin
      end
      ataf_pkg::CMD_SMRT: begin
        if (cylh_reg != ataf_pkg::SIG_HI || cyll_reg != ataf_pkg::SIG_LO) begin
          abort_next = 1'b1;
        end else if (feat_reg == ataf_pkg::SUB_STAT) begin
          cyll_next = fatal_reg ? ataf_pkg::BAD_LO : ataf_pkg::SIG_LO;
          cylh_next = fatal_reg ? ataf_pkg::BAD_HI : ataf_pkg::SIG_HI;
        end else if (feat_reg == ataf_pkg::SUB_ASAV) begin
          if (scnt_reg == ataf_pkg::ASAV_OFF) begin
            cfg_next.autosave = 1'b0;
          end else if (scnt_reg == ataf_pkg::ASAV_ON) begin
            cfg_next.autosave = 1'b1;
          end else begin
            abort_next = 1'b1;
          end
        end else begin
          abort_next = 1'b1;
        end
      end
      default: abort_next = 1'b1;
    endcase
    if (abort_next && op_reg != ataf_pkg::CMD_SETM) begin
      cfg_next = cfg;
      flush_next = 1'b0;
    end
  end

  // Command sequencer, settings and completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ataf_pkg::S_IDLE;
      cfg <= ataf_pkg::CFG_RST;
      keep_reg <= 1'b0;
      busy <= 1'b0;
      err_reg <= 1'b0;
      flush_req <= 1'b0;
      cmd_done <= 1'b0;
      data16_ok <= 1'b1;
    end else begin
      cmd_done <= 1'b0;
      flush_req <= 1'b0;
      data16_ok <= ~cfg.byte_mode;
      if (srst_go) begin
        state_reg <= ataf_pkg::S_IDLE;
        busy <= 1'b0;
        err_reg <= 1'b0;
        if (!keep_reg) begin
          cfg <= ataf_pkg::CFG_RST;
        end
      end else begin
        case (state_reg)
          ataf_pkg::S_IDLE: begin
            if (cmd_go) begin
              busy <= 1'b1;
              state_reg <= ataf_pkg::S_EXEC;
            end
          end
          ataf_pkg::S_EXEC: begin
            cfg <= cfg_next;
            err_reg <= abort_next;
            if (op_reg == ataf_pkg::CMD_SETF && !abort_next) begin
              if (feat_reg == ataf_pkg::F_KEEP) begin
                keep_reg <= 1'b1;
              end else if (feat_reg == ataf_pkg::F_REST) begin
                keep_reg <= 1'b0;
              end
            end
            if (flush_next) begin
              flush_req <= 1'b1;
              state_reg <= ataf_pkg::S_FLSH;
            end else begin
              busy <= 1'b0;
              cmd_done <= 1'b1;
              state_reg <= ataf_pkg::S_IDLE;
            end
          end
          ataf_pkg::S_FLSH: begin
            if (flush_done) begin
              busy <= 1'b0;
              cmd_done <= 1'b1;
              state_reg <= ataf_pkg::S_IDLE;
            end
          end
          default: state_reg <= ataf_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Sticky completion flag; a new completion beats a status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (cmd_done) begin
      done_reg <= 1'b1;
    end else if (st_rd) begin
      done_reg <= 1'b0;
    end
  end

  // Fatal error latch for the reliability status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fatal_reg <= 1'b0;
    end else if (fatal_err) begin
      fatal_reg <= 1'b1;
    end
  end

  // Sleep state and idle timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep <= 1'b0;
      idle_cnt <= '0;
    end else begin
      if (cmd_go || busy || sleep) begin
        idle_cnt <= '0;
      end else if (idle_cnt == T_END) begin
        idle_cnt <= '0;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
      if (cmd_go) begin
        sleep <= 1'b0;
      end else if (exec && !abort_next &&
                   (op_reg == ataf_pkg::CMD_SLP1 ||
                    op_reg == ataf_pkg::CMD_SLP2)) begin
        sleep <= 1'b1;
      end else if (!busy && idle_cnt == T_END) begin
        sleep <= 1'b1;
      end
    end
  end

  a_cmd_busy: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go |=> busy ##1 (busy || cmd_done))
    else $error("busy not raised on command");
  a_busy_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && !flush_next && !srst_go) |=> (!busy && cmd_done))
    else $error("busy not cleared at completion");
  a_byte_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && op_reg == ataf_pkg::CMD_SETF && feat_reg == ataf_pkg::F_B8ON
     && !srst_go) |=> cfg.byte_mode ##1 !data16_ok)
    else $error("byte mode not applied");
  a_smart_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && op_reg == ataf_pkg::CMD_SMRT && feat_reg == ataf_pkg::SUB_STAT
     && !abort_next && !fatal_reg) |=>
    (cyll_reg == ataf_pkg::SIG_LO && cylh_reg == ataf_pkg::SIG_HI))
    else $error("healthy signature wrong");
  a_smart_bad: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && op_reg == ataf_pkg::CMD_SMRT && feat_reg == ataf_pkg::SUB_STAT
     && !abort_next && fatal_reg) |=>
    (cyll_reg == ataf_pkg::BAD_LO && cylh_reg == ataf_pkg::BAD_HI))
    else $error("fatal signature wrong");
  a_multi_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && op_reg == ataf_pkg::CMD_SETM && scnt_reg == 8'h00 && !srst_go)
    |=> (!cfg.multi_en && !err_reg))
    else $error("zero count mishandled");
  a_bad_feat: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && op_reg == ataf_pkg::CMD_SETF && abort_next && !srst_go)
    |=> (err_reg && cfg == $past(cfg)))
    else $error("bad feature changed settings");
  a_sleep_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && (op_reg == ataf_pkg::CMD_SLP1 || op_reg == ataf_pkg::CMD_SLP2)
     && !srst_go) |=> (sleep && cmd_done && !busy))
    else $error("sleep command not completed");
  a_wake_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && sleep) |=> !sleep)
    else $error("command did not wake device");
  a_idle_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy && !cmd_go && !sleep && idle_cnt == T_END) |=> sleep)
    else $error("idle timer did not sleep");
  a_flush_req: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && flush_next && !srst_go) |=> (flush_req && busy) ##1 !flush_req)
    else $error("flush not requested");
endmodule
`default_nettype wire

/* File: tb/ataf_media_model.sv */
// Storage-side model answering cache flushes and raising fatal errors
`timescale 1ns/1ps
`default_nettype none
module ataf_media_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush_req,
  input wire logic [3:0] flush_lat,
  input wire logic fatal_cmd,
  output logic flush_done,
  output logic fatal_err
);
  logic [4:0] cnt_reg;
  // Flush completes flush_lat+2 cycles after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h00;
      flush_done <= 1'b0;
    end else if (flush_req) begin
      cnt_reg <= {1'b0, flush_lat} + 5'h01;
      flush_done <= 1'b0;
    end else begin
      flush_done <= (cnt_reg == 5'h01);
      if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    end
  end
  // Fatal error stays once raised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fatal_err <= 1'b0;
    else fatal_err <= fatal_err | fatal_cmd;
  end
endmodule
`default_nettype wire

/* File: tb/ata_feature_sleep_smart_cmds_tb.sv */
// Self-checking bench for the task-file command interpreter
`timescale 1ns/1ps
`default_nettype none
module ata_feature_sleep_smart_cmds_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fatal_cmd = 1'b0;
  logic [3:0] flush_lat = 4'h9;
  logic fatal_err;
  logic flush_done;
  ataf_pkg::ataf_cfg_s cfg;
  ataf_pkg::ataf_cfg_s exp;
  logic data16_ok;
  logic flush_req;
  logic sleep;
  logic busy;
  logic cmd_done;
  logic [31:0] rd;
  logic er;
  logic [7:0] nops [3] = '{8'h69, 8'h96, 8'h97};
  logic [7:0] slp [2] = '{8'he6, 8'h99};
  int mismatches = 0;
  int cmp_count = 0;
  int flushes = 0;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (flush_req === 1'b1) flushes++;

  ataf_top #(.IDLE_CYCLES(50), .MAX_PIO(3'h4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fatal_err(fatal_err), .flush_done(flush_done), .cfg(cfg),
    .data16_ok(data16_ok), .flush_req(flush_req), .sleep(sleep),
    .busy(busy), .cmd_done(cmd_done)
  );
  ataf_media_model media (
    .pclk(pclk), .presetn(presetn), .flush_req(flush_req),
    .flush_lat(flush_lat), .fatal_cmd(fatal_cmd),
    .flush_done(flush_done), .fatal_err(fatal_err)
  );

  task automatic fail(input string m);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w,
                     input string m);
    cmp_count++;
    if (g !== w) fail($sformatf("%s got %h want %h", m, g, w));
  endtask
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; result lands in rd and er
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) fail("no pready");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] mk,
                     input logic [31:0] w, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & mk, w, m);
  endtask
  task automatic chk_cfg();
    if (exp.multi_en) chk(32'(cfg), 32'(exp), "cfg");
    else chk(32'(cfg[25:8]), 32'(exp[25:8]), "cfg");
    chk({31'h0, data16_ok}, {31'h0, ~exp.byte_mode}, "data16");
  endtask
  // Issue a command, wait for completion, check results and status
  task automatic cmd(input logic [7:0] op, input logic [7:0] f,
                     input logic [7:0] s, input logic e);
    int n;
    n = 0;
    wr(8'h00, f);
    wr(8'h04, s);
    wr(8'h10, op);
    @(posedge pclk);
    chk({31'h0, busy}, 32'h1, "busy");
    while (cmd_done !== 1'b1 && n < 400) begin
      n++;
      @(posedge pclk);
    end
    if (n == 400) fail("no completion");
    if (f != 8'h82 || op != 8'hef) chk(32'(n), 32'h1, "latency");
    @(posedge pclk);
    chk_cfg();
    rdc(8'h10, 32'hb, {28'h0, 2'b10, e, 1'b0}, "status");
    rdc(8'h10, 32'h8, 32'h0, "done clr");
    rdc(8'h00, 32'h4, {29'h0, e, 2'b00}, "abort");
  endtask
  task automatic sm(input logic [7:0] f, input logic [7:0] s,
                    input logic [7:0] hi, input logic e);
    wr(8'h08, 8'h4f);
    wr(8'h0c, hi);
    cmd(8'hb0, f, s, e);
  endtask

  initial begin
    #(20000 * 25);
    fail("watchdog");
    wrap_up();
  end

  initial begin
    exp = ataf_pkg::CFG_RST;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_cfg();
    exp.byte_mode = 1'b1;
    cmd(8'hef, 8'h01, 8'h00, 1'b0);
    exp.byte_mode = 1'b0;
    cmd(8'hef, 8'h81, 8'h00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      exp.wcache = 1'b1;
      cmd(8'hef, 8'h02, 8'h00, 1'b0);
      exp.wcache = 1'b0;
      cmd(8'hef, 8'h82, 8'h00, 1'b0);
      chk(32'(flushes), 32'(i + 1), "flush");
      flush_lat <= 4'h0;
    end
    exp.iordy_dis = 1'b1;
    cmd(8'hef, 8'h03, 8'h01, 1'b0);
    exp.iordy_dis = 1'b0;
    exp.pio_mode = 3'h3;
    cmd(8'hef, 8'h03, 8'h0b, 1'b0);
    cmd(8'hef, 8'h03, 8'h0d, 1'b1);
    exp.pio_mode = 3'h0;
    cmd(8'hef, 8'h03, 8'h00, 1'b0);
    exp.mw_en = 1'b1;
    exp.mw_mode = 3'h2;
    cmd(8'hef, 8'h03, 8'h22, 1'b0);
    exp.mw_en = 1'b0;
    exp.udma_en = 1'b1;
    exp.udma_mode = 3'h5;
    cmd(8'hef, 8'h03, 8'h45, 1'b0);
    cmd(8'hef, 8'h03, 8'h18, 1'b1);
    cmd(8'hef, 8'h03, 8'h80, 1'b1);
    rdc(8'h14, 32'h03ff_ffff, 32'(exp), "cfg read");
    exp.ext_pwr = 1'b1;
    cmd(8'hef, 8'h09, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) cmd(8'hef, nops[i], 8'h00, 1'b0);
    cmd(8'hef, 8'h42, 8'h00, 1'b1);
    cmd(8'h20, 8'h00, 8'h00, 1'b1);
    exp.ext_pwr = 1'b0;
    cmd(8'hef, 8'h89, 8'h00, 1'b0);
    exp.lookahead = 1'b1;
    cmd(8'hef, 8'haa, 8'h00, 1'b0);
    exp.lookahead = 1'b0;
    cmd(8'hef, 8'h55, 8'h00, 1'b0);
    exp.multi_en = 1'b1;
    exp.multi_cnt = 8'h80;
    cmd(8'hc6, 8'h00, 8'h80, 1'b0);
    exp.multi_en = 1'b0;
    cmd(8'hc6, 8'h00, 8'h00, 1'b0);
    exp.multi_en = 1'b1;
    exp.multi_cnt = 8'h08;
    cmd(8'hc6, 8'h00, 8'h08, 1'b0);
    exp.multi_en = 1'b0;
    cmd(8'hc6, 8'h00, 8'h81, 1'b1);
    for (int i = 0; i < 2; i++) begin
      cmd(slp[i], 8'h00, 8'h00, 1'b0);
      chk({31'h0, sleep}, 32'h1, "sleep");
      cmd(8'hef, 8'h69, 8'h00, 1'b0);
      chk({31'h0, sleep}, 32'h0, "wake");
    end
    repeat (30) @(posedge pclk);
    chk({31'h0, sleep}, 32'h0, "early idle");
    repeat (30) @(posedge pclk);
    chk({31'h0, sleep}, 32'h1, "idle sleep");
    rdc(8'h10, 32'h4, 32'h4, "sleep bit");
    sm(8'hda, 8'h00, 8'hc2, 1'b0);
    rdc(8'h08, 32'hff, 32'h4f, "mid");
    rdc(8'h0c, 32'hff, 32'hc2, "high");
    sm(8'hda, 8'h00, 8'h00, 1'b1);
    exp.autosave = 1'b1;
    sm(8'hd2, 8'hf1, 8'hc2, 1'b0);
    sm(8'hd2, 8'h55, 8'hc2, 1'b1);
    exp.autosave = 1'b0;
    sm(8'hd2, 8'h00, 8'hc2, 1'b0);
    sm(8'hd8, 8'h00, 8'hc2, 1'b1);
    fatal_cmd <= 1'b1;
    sm(8'hda, 8'h00, 8'hc2, 1'b0);
    rdc(8'h08, 32'hff, 32'hf4, "mid bad");
    rdc(8'h0c, 32'hff, 32'h2c, "high bad");
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk({31'h0, er}, 32'h1, "slverr");
    exp.multi_en = 1'b1;
    exp.multi_cnt = 8'h10;
    cmd(8'hc6, 8'h00, 8'h10, 1'b0);
    cmd(8'hef, 8'h66, 8'h00, 1'b0);
    wr(8'h18, 8'h01);
    repeat (2) @(posedge pclk);
    chk_cfg();
    rdc(8'h18, 32'h1, 32'h1, "keep");
    cmd(8'hef, 8'hcc, 8'h00, 1'b0);
    wr(8'h18, 8'h01);
    exp = ataf_pkg::CFG_RST;
    repeat (2) @(posedge pclk);
    chk_cfg();
    exp.lookahead = 1'b1;
    cmd(8'hef, 8'haa, 8'h00, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    exp = ataf_pkg::CFG_RST;
    chk_cfg();
    wrap_up();
  end
endmodule
`default_nettype wire
